// ===== rtl/video_serializer_regs.vh
`ifndef VIDEO_SERIALIZER_REGS_VH
`define VIDEO_SERIALIZER_REGS_VH

// reset values of the two software registers
`define VID_CONFIG_RESET        32'h0000_0000
`define VID_SCALE_RESET         32'h0000_0000

// video_config field positions
`define VID_MODE_HI             30
`define VID_MODE_LO             29
`define VID_DEPTH_BIT           28
`define VID_BCAST_CLR_BIT       27
`define VID_BBAND_CLR_BIT       26
`define VID_AUDIO_HI            25
`define VID_AUDIO_LO            23
`define VID_BANK_HI             11
`define VID_BANK_LO             9
`define VID_MASK_HI             7
`define VID_MASK_LO             0

// video_scale field positions
`define VID_PIXEL_HI            19
`define VID_PIXEL_LO            12
`define VID_FRAME_HI            11
`define VID_FRAME_LO            0

// video_mode_field codes
`define VID_MODE_OFF            2'h0
`define VID_MODE_VGA            2'h1
`define VID_MODE_COMP1          2'h2
`define VID_MODE_COMP2          2'h3

// pin_bank_select: codes at or above this are reserved
`define VID_BANK_LIMIT          3'h4

// zero-field meanings, in pll clocks
`define VID_PIXEL_ZERO_CLKS     9'h100
`define VID_FRAME_ZERO_CLKS     13'h1000

// last pixel index per colour depth
`define VID_LAST_PIX_1BIT       5'h1f
`define VID_LAST_PIX_2BIT       5'h0f

`endif

// ===== rtl/video_pin_router.v
`timescale 1ns/100ps
`default_nettype none

// steers one video byte onto an eight-pin bank under the pin mask
module video_pin_router (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        ce_i,
    input  wire        active_i,
    input  wire [2:0]  bank_i,
    input  wire [7:0]  mask_i,
    input  wire [7:0]  byte_i,
    output reg  [31:0] pin_out_o,
    output reg  [31:0] pin_oe_o
);

    reg  [31:0] out_d;
    reg  [31:0] oe_d;
    wire [7:0]  en;

    assign en = active_i ? mask_i : 8'h00; // RULE_12

    always @* begin
        out_d = 32'h0000_0000;
        oe_d  = 32'h0000_0000;
        case (bank_i) // RULE_11
            3'h0: begin
                out_d[7:0]  = byte_i & en;
                oe_d[7:0]   = en;
            end
            3'h1: begin
                out_d[15:8] = byte_i & en;
                oe_d[15:8]  = en;
            end
            3'h2: begin
                out_d[23:16] = byte_i & en;
                oe_d[23:16]  = en;
            end
            3'h3: begin
                out_d[31:24] = byte_i & en;
                oe_d[31:24]  = en;
            end
            default: begin
                // reserved bank codes leave every pin undriven
                out_d = 32'h0000_0000; // RULE_19
                oe_d  = 32'h0000_0000; // RULE_19
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_out_o <= 32'h0000_0000;
            pin_oe_o  <= 32'h0000_0000;
        end else if (ce_i) begin
            pin_out_o <= out_d;
            pin_oe_o  <= oe_d;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/per_core_video_serializer.v
// Function
// RULE_01 - counter A pll must run for timing
// RULE_02 - software starts pll, scale, config, then handoff
// RULE_03 - handoff stalls forever without pll clocks
// RULE_04 - mode 00 off, 01 parallel colour byte
// RULE_05 - modes 10/11 place broadcast and baseband nibbles
// RULE_06 - depth bit: 32x1 or 16x2 pixels
// RULE_07 - bit 27 gates colour on broadcast
// RULE_08 - bit 26 gates colour on baseband
// RULE_09 - bits 25:23 pick aural source core
// RULE_10 - aural source core supplies modulated subcarrier
// RULE_11 - bank field picks pins; codes 100-111 reserved
// RULE_12 - mask gates each pin of bank
// RULE_13 - pixel period in pll clocks, zero=256
// RULE_14 - frame period in pll clocks, zero=4096
// RULE_15 - one pixel and colour long per frame
// RULE_16 - pixels leave least significant first
// RULE_17 - last pixel repeats until frame ends
// RULE_18 - boundary without waiting core latches buses anyway
// RULE_19 - reserved bank code drives no pins
`timescale 1ns/100ps
`default_nettype none
`include "video_serializer_regs.vh"

module per_core_video_serializer (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        ce_i,
    input  wire        pll_a_tick_i,
    input  wire [7:0]  aural_pll_i,
    input  wire        config_wr_i,
    input  wire [31:0] config_wdata_i,
    input  wire        scale_wr_i,
    input  wire [31:0] scale_wdata_i,
    input  wire        handoff_wait_i,
    input  wire [31:0] colour_bus_i,
    input  wire [31:0] pixel_bus_i,
    output reg         handoff_done_o,
    output reg         frame_start_o,
    output reg  [31:0] video_config_o,
    output reg  [31:0] video_scale_o,
    output wire [31:0] pin_out_o,
    output wire [31:0] pin_oe_o
);

    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_SHIFT = 3'b010;
    localparam [2:0] ST_HOLD  = 3'b100;

    // modulates one colour byte: luma in 2:0, colour flag in 3, hue in 7:4
    function [3:0] modulate;
        input [7:0] cbyte;
        input       clr_en;
        input [3:0] phase;
        reg   [3:0] hue_sum;
        reg   [3:0] luma;
        begin
            hue_sum = phase + cbyte[7:4];
            luma    = {1'b0, cbyte[2:0]};
            if (clr_en && cbyte[3]) begin
                if (hue_sum[3])
                    modulate = luma + 4'h1;
                else if (luma != 4'h0)
                    modulate = luma - 4'h1;
                else
                    modulate = 4'h0;
            end else begin
                modulate = luma;
            end
        end
    endfunction

    // maps a stored period field to its clock count, zero meaning full range
    function [12:0] period_of;
        input [11:0] field;
        input        is_frame;
        begin
            if (is_frame)
                period_of = (field == 12'h000) ? `VID_FRAME_ZERO_CLKS
                                               : {1'b0, field};
            else
                period_of = (field[7:0] == 8'h00) ? {4'h0, `VID_PIXEL_ZERO_CLKS}
                                                  : {5'h00, field[7:0]};
        end
    endfunction

    // true on the pll tick that ends a count
    function count_done;
        input [12:0] count;
        input        tick;
        begin
            count_done = tick && (count == 13'h0001);
        end
    endfunction

    // advances the pixel shifter by one pixel of the current depth
    function [31:0] next_shift;
        input [31:0] bits;
        input        two_bit;
        begin
            if (two_bit)
                next_shift = {2'b00, bits[31:2]};
            else
                next_shift = {1'b0, bits[31:1]};
        end
    endfunction

    // picks colour byte k of the colour long
    function [7:0] select_colour;
        input [31:0] colours;
        input [1:0]  idx;
        begin
            case (idx)
                2'h0:    select_colour = colours[7:0];
                2'h1:    select_colour = colours[15:8];
                2'h2:    select_colour = colours[23:16];
                default: select_colour = colours[31:24];
            endcase
        end
    endfunction

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [12:0] frame_cnt_q;
    reg  [8:0]  pixel_cnt_q;
    reg  [4:0]  pix_idx_q;
    reg  [31:0] shift_q;
    reg  [31:0] colours_q;
    reg  [3:0]  phase_q;
    reg  [7:0]  out_byte_q;
    reg  [7:0]  out_byte_d;
    reg         active_q;

    wire [1:0]  mode;
    wire        depth_2bit;
    wire        bcast_clr;
    wire        bband_clr;
    wire [2:0]  audio_sel;
    wire [2:0]  bank;
    wire [7:0]  mask;
    wire [12:0] pixel_clks;
    wire [12:0] frame_clks;
    wire        frame_end;
    wire        pixel_end;
    wire [4:0]  last_idx;
    wire [1:0]  colour_idx;
    wire [7:0]  colour_byte;
    wire [3:0]  bcast_nib;
    wire [3:0]  bband_nib;
    wire [3:0]  bcast_mod;
    wire        aural_bit;

    assign mode       = video_config_o[`VID_MODE_HI:`VID_MODE_LO];
    assign depth_2bit = video_config_o[`VID_DEPTH_BIT];
    assign bcast_clr  = video_config_o[`VID_BCAST_CLR_BIT];
    assign bband_clr  = video_config_o[`VID_BBAND_CLR_BIT];
    assign audio_sel  = video_config_o[`VID_AUDIO_HI:`VID_AUDIO_LO];
    assign bank       = video_config_o[`VID_BANK_HI:`VID_BANK_LO];
    assign mask       = video_config_o[`VID_MASK_HI:`VID_MASK_LO];

    assign pixel_clks = period_of({4'h0, video_scale_o[`VID_PIXEL_HI:`VID_PIXEL_LO]},
                                  1'b0); // RULE_13
    assign frame_clks = period_of(video_scale_o[`VID_FRAME_HI:`VID_FRAME_LO],
                                  1'b1); // RULE_14

    // nothing moves without pll clocks, so a waiting core is never released
    assign frame_end  = count_done(frame_cnt_q, pll_a_tick_i); // RULE_03
    assign pixel_end  = count_done({4'h0, pixel_cnt_q}, pll_a_tick_i);

    assign last_idx   = depth_2bit ? `VID_LAST_PIX_2BIT : `VID_LAST_PIX_1BIT; // RULE_06

    // current pixel sits in the low bits of the shifter
    assign colour_idx = depth_2bit ? shift_q[1:0] : {1'b0, shift_q[0]}; // RULE_06 RULE_16

    assign colour_byte = select_colour(colours_q, colour_idx);

    assign aural_bit  = aural_pll_i[audio_sel]; // RULE_09

    // broadcast nibble carries the aural subcarrier in its top bit
    assign bcast_mod  = modulate(colour_byte, bcast_clr, phase_q); // RULE_07
    assign bcast_nib  = {aural_bit, bcast_mod[2:0]};
    assign bband_nib  = modulate(colour_byte, bband_clr, phase_q); // RULE_08

    // software registers
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            video_config_o <= `VID_CONFIG_RESET;
            video_scale_o  <= `VID_SCALE_RESET;
        end else if (ce_i) begin
            if (config_wr_i)
                video_config_o <= config_wdata_i;
            if (scale_wr_i)
                video_scale_o  <= scale_wdata_i;
        end
    end

    // frame sequencing
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (frame_end)
                    state_d = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (frame_end)
                    state_d = ST_SHIFT;
                else if (pixel_end && (pix_idx_q == last_idx))
                    state_d = ST_HOLD; // RULE_17
            end
            ST_HOLD: begin
                if (frame_end)
                    state_d = ST_SHIFT;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q     <= ST_IDLE;
            frame_cnt_q <= 13'h0001;
            pixel_cnt_q <= 9'h001;
            pix_idx_q   <= 5'h00;
            shift_q     <= 32'h0000_0000;
            colours_q   <= 32'h0000_0000;
            phase_q     <= 4'h0;
        end else if (ce_i) begin
            state_q <= state_d;
            if (pll_a_tick_i)
                phase_q <= phase_q + 4'h1;
            if (frame_end) begin
                // buses are latched whether or not the core waits
                colours_q   <= colour_bus_i; // RULE_15 RULE_18
                shift_q     <= pixel_bus_i; // RULE_15 RULE_18
                frame_cnt_q <= frame_clks; // RULE_14
                pixel_cnt_q <= pixel_clks[8:0]; // RULE_13
                pix_idx_q   <= 5'h00;
            end else if (pll_a_tick_i) begin
                frame_cnt_q <= frame_cnt_q - 13'h0001;
                if (pixel_end) begin
                    pixel_cnt_q <= pixel_clks[8:0]; // RULE_13
                    if (state_q == ST_SHIFT && pix_idx_q != last_idx) begin
                        pix_idx_q <= pix_idx_q + 5'h01;
                        shift_q <= next_shift(shift_q, depth_2bit); // RULE_16
                    end
                end else begin
                    pixel_cnt_q <= pixel_cnt_q - 9'h001;
                end
            end
        end
    end

    // handoff answer and frame marker
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            handoff_done_o <= 1'b0;
            frame_start_o  <= 1'b0;
        end else if (ce_i) begin
            handoff_done_o <= frame_end && handoff_wait_i; // RULE_03 RULE_15
            frame_start_o  <= frame_end;
        end
    end

    // output byte per video mode
    always @* begin
        out_byte_d = 8'h00;
        case (mode)
            `VID_MODE_VGA:   out_byte_d = colour_byte; // RULE_04
            `VID_MODE_COMP1: out_byte_d = {bcast_nib, bband_nib}; // RULE_05
            `VID_MODE_COMP2: out_byte_d = {bband_nib, bcast_nib}; // RULE_05
            default:         out_byte_d = 8'h00; // RULE_04
        endcase
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_byte_q <= 8'h00;
            active_q   <= 1'b0;
        end else if (ce_i) begin
            out_byte_q <= out_byte_d;
            // no pins are driven until the first frame has been fetched
            active_q   <= (mode != `VID_MODE_OFF) && (state_q != ST_IDLE); // RULE_04
        end
    end

    video_pin_router u_router (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .active_i  (active_q),
        .bank_i    (bank),
        .mask_i    (mask),
        .byte_i    (out_byte_q),
        .pin_out_o (pin_out_o),
        .pin_oe_o  (pin_oe_o)
    );

endmodule

`default_nettype wire

// ===== verif/per_core_video_serializer_checker.sv
`timescale 1ns/100ps
`default_nettype none
module per_core_video_serializer_checker (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        ce_i,
    input wire logic        pll_a_tick_i,
    input wire logic        scale_wr_i,
    input wire logic [31:0] scale_wdata_i,
    input wire logic        handoff_wait_i,
    input wire logic        handoff_done_o,
    input wire logic        frame_start_o,
    input wire logic [31:0] video_config_o,
    input wire logic [31:0] video_scale_o,
    input wire logic [31:0] pin_out_o,
    input wire logic [31:0] pin_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire [31:0] bank_oe = {24'h0, video_config_o[7:0]} << (8 * video_config_o[11:9]);
    chk_mode_off: assert property (
        (video_config_o[30:29] == 2'h0)[*3] |-> pin_oe_o == 32'h0) else $error("pins on in mode off");
    chk_bank_reserved: assert property (
        (video_config_o[11:9] >= 3'h4)[*3] |-> pin_oe_o == 32'h0) else $error("reserved bank drives");
    chk_oe_in_bank: assert property (
        $stable(video_config_o)[*3] |-> (pin_oe_o & ~bank_oe) == 32'h0) else $error("pin off bank");
    chk_out_gated: assert property (
        (pin_out_o & ~pin_oe_o) == 32'h0) else $error("level on undriven pin");
    chk_done_at_frame: assert property (
        handoff_done_o |-> frame_start_o && $past(handoff_wait_i)) else $error("stray release");
    chk_wait_released: assert property (
        frame_start_o && $past(handoff_wait_i) |-> handoff_done_o) else $error("core not released");
    chk_start_on_tick: assert property (
        frame_start_o |-> $past(pll_a_tick_i && ce_i)) else $error("frame without pll tick");
    chk_frame_gap: assert property (
        frame_start_o && video_scale_o[11:0] == 12'h008 |=> !frame_start_o [*7])
        else $error("frame too short");
    chk_scale_write: assert property (
        ce_i && scale_wr_i |=> video_scale_o == $past(scale_wdata_i)) else $error("scale lost");
endmodule
bind per_core_video_serializer per_core_video_serializer_checker chk_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .pll_a_tick_i(pll_a_tick_i),
    .scale_wr_i(scale_wr_i), .scale_wdata_i(scale_wdata_i), .handoff_wait_i(handoff_wait_i),
    .handoff_done_o(handoff_done_o), .frame_start_o(frame_start_o),
    .video_config_o(video_config_o), .video_scale_o(video_scale_o),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
`default_nettype wire

// ===== verif/pin_display_model.sv
`timescale 1ns/100ps
`default_nettype none
// display side: undriven pins float, shown as a level that flips every cycle
module pin_display_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] pin_out_i,
    input  wire logic [31:0] pin_oe_i,
    output wire logic [31:0] pin_level_o
);
    logic [31:0] prev_q = 32'h0;
    always @(posedge clk_i) begin
        prev_q <= pin_level_o;
    end
    assign pin_level_o = (pin_out_i & pin_oe_i) | (~prev_q & ~pin_oe_i);
endmodule
`default_nettype wire

// ===== verif/per_core_video_serializer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module per_core_video_serializer_tb;
    logic clk_i = 0, sys_rst_i = 1, ce_i = 1, pll_a_tick_i = 1, handoff_wait_i = 1;
    logic config_wr_i = 0, scale_wr_i = 0;
    logic [7:0]  aural_pll_i = 8'ha5;
    logic [31:0] config_wdata_i = 32'h0, scale_wdata_i = 32'h0;
    logic [31:0] colour_bus_i = 32'h4433_2211, pixel_bus_i = 32'hc000_00e4;
    logic [31:0] video_config_o, video_scale_o, pin_out_o, pin_oe_o, pin_level, exp_pins;
    logic        handoff_done_o, frame_start_o, ok;
    int          miscompares = 0, comparisons = 0, b, m;
    always #5 clk_i = ~clk_i;
    per_core_video_serializer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .pll_a_tick_i(pll_a_tick_i), .aural_pll_i(aural_pll_i), .config_wr_i(config_wr_i),
        .config_wdata_i(config_wdata_i), .scale_wr_i(scale_wr_i), .scale_wdata_i(scale_wdata_i),
        .handoff_wait_i(handoff_wait_i), .colour_bus_i(colour_bus_i), .pixel_bus_i(pixel_bus_i),
        .handoff_done_o(handoff_done_o), .frame_start_o(frame_start_o),
        .video_config_o(video_config_o), .video_scale_o(video_scale_o),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
    pin_display_model display (.clk_i(clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
        .pin_level_o(pin_level));
    task stop_test;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // sel high writes video_config, low writes video_scale; readback one cycle later
    task wr(input logic sel, input logic [31:0] d);
        @(posedge clk_i);
        config_wr_i <= sel;
        scale_wr_i <= !sel;
        if (sel) config_wdata_i <= d; else scale_wdata_i <= d;
        @(posedge clk_i);
        config_wr_i <= 0;
        scale_wr_i <= 0;
        #1 check(sel ? video_config_o : video_scale_o, d);
    endtask
    task await_frame;
        int n;
        n = 0;
        repeat (2) @(posedge clk_i);
        #1;
        while (frame_start_o !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            #1 n++;
        end
        check({31'h0, frame_start_o}, 32'h1);
    endtask
    // pins lag the boundary by two cycles; pll ticks every cycle
    task frame_check(input int pp, input int w, input int bk, input logic [7:0] mk, input int cnt);
        int t, idx, p;
        logic [7:0]  cb;
        logic [31:0] eo;
        @(posedge clk_i);
        for (t = 0; t < cnt; t++) begin
            @(posedge clk_i);
            #1 idx = t / pp;
            if (idx > 32 / w - 1) idx = 32 / w - 1;
            p = (pixel_bus_i >> (idx * w)) & ((1 << w) - 1);
            cb = 8'(colour_bus_i >> (8 * p));
            eo = {24'h0, mk} << (8 * bk);
            check(pin_oe_o, eo);
            check(pin_level & eo, {24'h0, cb & mk} << (8 * bk));
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 0;
        @(posedge clk_i);
        #1 check(video_config_o | pin_oe_o, 32'h0);
        check({31'h0, frame_start_o}, 32'h1);
        wr(0, 32'h0000_1014);
        wr(1, 32'h3000_02ff);
        await_frame;
        check({31'h0, handoff_done_o}, 32'h1);
        frame_check(1, 2, 1, 8'hff, 19);
        wr(0, 32'h0000_2008);
        wr(1, 32'h2000_060f);
        pixel_bus_i <= 32'h8000_0006;
        await_frame;
        frame_check(2, 1, 3, 8'h0f, 7);
        handoff_wait_i <= 0;
        pixel_bus_i <= 32'h0000_0009;
        await_frame;
        check({31'h0, handoff_done_o}, 32'h0);
        frame_check(2, 1, 3, 8'h0f, 7);
        handoff_wait_i <= 1;
        pixel_bus_i <= 32'h0;
        await_frame;
        for (b = 0; b < 8; b++) begin
            wr(1, 32'h3000_005a | (b << 9));
            repeat (3) @(posedge clk_i);
            #1 check(pin_oe_o, {24'h0, 8'h5a} << (8 * b));
            check(pin_out_o, {24'h0, 8'h10} << (8 * b));
        end
        wr(1, 32'h1000_02ff);
        repeat (3) @(posedge clk_i);
        #1 check(pin_oe_o, 32'h0);
        colour_bus_i <= 32'h0505_0505;
        await_frame;
        for (m = 2; m < 4; m++) begin
            for (b = 0; b < 8; b++) begin
                wr(1, (m << 29) | (b << 23) | 32'hff);
                repeat (3) @(posedge clk_i);
                #1 exp_pins = (m == 2) ? {24'h0, aural_pll_i[b], 7'h55}
                                       : {24'h0, 4'h5, aural_pll_i[b], 3'h5};
                check(pin_out_o, exp_pins);
            end
        end
        colour_bus_i <= 32'h0d0d_0d0d;
        await_frame;
        for (m = 0; m < 2; m++) begin
            wr(1, 32'h4000_00ff | (m ? 32'h0400_0000 : 32'h0800_0000));
            // pins show a new configuration two cycles after it is stored
            @(posedge clk_i);
            repeat (18) begin
                @(posedge clk_i);
                #1 ok = m ? (pin_out_o[3:0] inside {4'h4, 4'h6}) && pin_out_o[6:4] == 3'h5
                        : pin_out_o[3:0] == 4'h5 && (pin_out_o[6:4] inside {3'h4, 3'h6});
                check({31'h0, ok}, 32'h1);
            end
        end
        // no pll ticks, then ticks under a low clock enable: no boundary may appear
        for (m = 0; m < 2; m++) begin
            pll_a_tick_i <= (m == 1);
            ce_i <= (m == 0);
            repeat (20) begin
                @(posedge clk_i);
                #1 check({31'h0, frame_start_o | handoff_done_o}, 32'h0);
            end
        end
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        stop_test;
    end
endmodule
`default_nettype wire
